/* File: cmem_chk.sv */
// Concurrent checks on the ports of the core stack and banked memory block.
`timescale 1ns/1ns
`default_nettype none
module cmem_chk (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        push_in,
  input wire logic        pop_in,
  input wire logic [14:0] push_addr_in,
  input wire logic        stack_fault_reset_en_in,
  input wire logic [4:0]  stack_level_out,
  input wire logic [14:0] top_addr_out,
  input wire logic        stack_overflow_flag_out,
  input wire logic        stack_underflow_flag_out,
  input wire logic        soft_reset_out,
  input wire logic        ptr_load_in,
  input wire logic        ptr_sel_in,
  input wire logic [15:0] ptr_value_in,
  input wire logic [15:0] indirect_pointer0_out,
  input wire logic [15:0] indirect_pointer1_out,
  input wire logic        access_in,
  input wire logic        indirect_in,
  input wire logic [6:0]  offset_in,
  input wire logic        sfr_sel_out,
  input wire logic [4:0]  sfr_index_out,
  input wire logic        stall_out,
  input wire logic        done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Fault conditions; push wins over pop, so a pop alongside a push never underflows.
  wire ovf_c = push_in && stack_level_out == 5'h10;
  wire unf_c = pop_in && !push_in && stack_level_out == 5'h00;
  level_max_a: assert property (stack_level_out <= 5'h10) else $error("stack level above 16");
  push_ok_a: assert property (push_in && stack_level_out < 5'h10 |=>
    stack_level_out == $past(stack_level_out) + 5'h01 && top_addr_out == $past(push_addr_in))
    else $error("push did not land on top");
  ovf_flag_a: assert property (ovf_c |=> stack_overflow_flag_out && stack_level_out == 5'h10)
    else $error("overflow not flagged");
  unf_flag_a: assert property (unf_c |=> stack_underflow_flag_out && stack_level_out == 5'h00)
    else $error("underflow not flagged");
  fault_reset_a: assert property ((ovf_c || unf_c) && stack_fault_reset_en_in |=> soft_reset_out)
    else $error("stack fault gave no reset");
  no_reset_a: assert property ((ovf_c || unf_c) && !stack_fault_reset_en_in |=> !soft_reset_out)
    else $error("reset while fault reset disabled");
  ptr_load_a: assert property (ptr_load_in && !ptr_sel_in |=>
    indirect_pointer0_out == $past(ptr_value_in) && $stable(indirect_pointer1_out))
    else $error("pointer load not independent");
  prog_wait_a: assert property (stall_out |=> !done_out ##1 done_out)
    else $error("program fetch timing wrong");
  // The cycle after a program fetch request is the fetch itself, where access is ignored.
  sfr_decode_a: assert property (access_in && !indirect_in && !stall_out && !$past(stall_out) &&
    offset_in >= 7'h0c && offset_in <= 7'h1f |-> sfr_sel_out && sfr_index_out == 5'(offset_in - 7'h0c))
    else $error("special register decode wrong");
  cover property (ovf_c);
  cover property (unf_c);
  cover property (soft_reset_out);
  cover property (stall_out);
endmodule // cmem_chk
`default_nettype wire

/* File: cmem_core.sv */
// Core memory block: return stack, indirect pointers, banked data map, shadows.
// Notes on behaviour
// RULE1 - Return stack holds sixteen entries of fifteen bits each.
// RULE2 - Overflowing push or empty pop sets its flag in the power-control status.
// RULE3 - With fault reset enabled, a stack fault also requests a software reset.
// RULE4 - Two independent sixteen-bit indirect pointers are provided.
// RULE5 - Each pointer reaches every file register and program memory.
// RULE6 - Indirect access to program memory costs one extra instruction cycle.
// RULE7 - General RAM is also reachable as one linear unbanked region.
// RULE8 - Special registers fill offsets 0Ch to 1Fh of every bank.
// RULE9 - Each bank holds at most eighty bytes of general RAM after the special registers; the code maps it in bank 0 only.
// RULE10 - Offsets 70h to 7Fh of every bank map to one shared common RAM.
// RULE11 - Interrupt entry saves selected registers to shadows; return restores them.
// RULE12 - The instruction set has 49 instructions including pointer operations.
// RULE13 - Offsets 00h to 0Bh of every bank decode to the twelve core registers.
// RULE14 - With fault reset disabled, a stack fault only sets its flag.
`timescale 1ns/1ns
`default_nettype none
module cmem_core
  import cmem_pkg::*;
#(
  parameter int unsigned GRAM_SIZE   = 80,
  parameter int unsigned COMMON_SIZE = 16
) (
  input  wire logic                 clk_in,
  input  wire logic                 srst_in,
  // Stack port.
  input  wire logic                 push_in,
  input  wire logic                 pop_in,
  input  wire logic [14:0]          push_addr_in,
  output logic [14:0]               top_addr_out,
  output logic [4:0]                stack_level_out,
  input  wire logic                 stack_fault_reset_en_in,
  output logic                      stack_overflow_flag_out,
  output logic                      stack_underflow_flag_out,
  input  wire logic                 flags_clear_in,
  output logic                      soft_reset_out,
  // Pointer loads.
  input  wire logic                 ptr_load_in,
  input  wire logic                 ptr_sel_in,
  input  wire logic [15:0]          ptr_value_in,
  input  wire logic                 ptr_inc_in,
  output logic [15:0]               indirect_pointer0_out,
  output logic [15:0]               indirect_pointer1_out,
  // Data access.
  input  wire logic                 access_in,
  input  wire logic                 indirect_in,
  input  wire logic                 write_in,
  input  wire logic [4:0]           bank_in,
  input  wire logic [6:0]           offset_in,
  input  wire logic [7:0]           wdata_in,
  output logic [7:0]                rdata_out,
  output logic                      stall_out,
  output logic                      done_out,
  output logic                      sfr_sel_out,
  output logic [4:0]                sfr_index_out,
  input  wire logic [7:0]           sfr_rdata_in,
  output logic                      prog_req_out,
  output logic [14:0]               prog_addr_out,
  input  wire logic [13:0]          prog_data_in,
  // Core register file view and interrupt shadowing.
  input  wire logic                 irq_entry_in,
  input  wire logic                 irq_return_in,
  output logic [7:0]                core_reg_out [CORE_REGS]
);
  cmem_target_type target;
  cmem_state_type  state_r, state_nxt;
  logic [6:0]      index;
  logic [14:0]     stack_r [STACK_DEPTH];
  logic [14:0]     stack_nxt [STACK_DEPTH];
  logic [4:0]      sp_r, sp_nxt;
  logic            ovf_r, ovf_nxt, unf_r, unf_nxt, srst_r, srst_nxt;
  logic [15:0]     ptr_r [2];
  logic [15:0]     ptr_nxt [2];
  logic [7:0]      gram_r [GRAM_SIZE];
  logic [7:0]      gram_nxt [GRAM_SIZE];
  logic [7:0]      com_r [COMMON_SIZE];
  logic [7:0]      com_nxt [COMMON_SIZE];
  logic [7:0]      creg_r [CORE_REGS];
  logic [7:0]      creg_nxt [CORE_REGS];
  logic [7:0]      shadow_r [CORE_REGS];
  logic [7:0]      shadow_nxt [CORE_REGS];
  logic [7:0]      rdata_r, rdata_nxt;
  logic            done_r, done_nxt;
  logic [15:0]     cur_ptr;
  logic [14:0]     prog_addr;
  logic            do_access;

  // The selected pointer addresses the unified space; direct access uses bank.
  assign cur_ptr = ptr_r[ptr_sel_in];

  cmem_decode u_decode (
    .direct_in     (!indirect_in),
    .bank_in       (bank_in),
    .offset_in     (offset_in),
    .pointer_in    (cur_ptr),
    .target_out    (target),
    .index_out     (index),
    .prog_addr_out (prog_addr)
  );

  // Stack: a push at full depth and a pop when empty leave the stack intact.
  always_comb begin
    stack_nxt = stack_r;
    sp_nxt    = sp_r;
    ovf_nxt   = ovf_r & ~flags_clear_in;
    unf_nxt   = unf_r & ~flags_clear_in;
    srst_nxt  = 1'b0;
    if (push_in) begin
      if (sp_r == 5'(STACK_DEPTH)) begin
        ovf_nxt  = 1'b1; // RULE2
        srst_nxt = stack_fault_reset_en_in; // RULE3 RULE14
      end else begin
        stack_nxt[sp_r[3:0]] = push_addr_in; // RULE1
        sp_nxt               = sp_r + 5'h01;
      end
    end else if (pop_in) begin
      if (sp_r == SP_RESET) begin
        unf_nxt  = 1'b1; // RULE2
        srst_nxt = stack_fault_reset_en_in; // RULE3 RULE14
      end else begin
        sp_nxt = sp_r - 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sp_r   <= SP_RESET;
      ovf_r  <= 1'b0;
      unf_r  <= 1'b0;
      srst_r <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) stack_r[i] <= 15'h0000;
    end else begin
      sp_r    <= sp_nxt;
      ovf_r   <= ovf_nxt;
      unf_r   <= unf_nxt;
      srst_r  <= srst_nxt;
      stack_r <= stack_nxt;
    end
  end

  assign top_addr_out             = (sp_r == SP_RESET) ? 15'h0000 : stack_r[4'(sp_r - 5'h01)];
  assign stack_level_out          = sp_r;
  assign stack_overflow_flag_out  = ovf_r;
  assign stack_underflow_flag_out = unf_r;
  assign soft_reset_out           = srst_r;

  // Program-memory reads through a pointer wait one cycle for the word.
  assign do_access = access_in && (state_r == CMEM_ST_IDLE);
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CMEM_ST_IDLE: begin
        if (access_in && indirect_in && target == CMEM_TGT_PROG) begin
          state_nxt = CMEM_ST_FETCH; // RULE6
        end
      end
      CMEM_ST_FETCH: state_nxt = CMEM_ST_IDLE;
    endcase
  end

  assign stall_out     = do_access && indirect_in && target == CMEM_TGT_PROG; // RULE6
  assign prog_req_out  = stall_out;
  assign prog_addr_out = prog_addr;
  assign sfr_sel_out   = do_access && target == CMEM_TGT_SFR;
  assign sfr_index_out = index[4:0];

  // Data path: writes land in their region; reads are registered.
  // Core registers and common RAM ignore the bank, which is what makes them
  // usable from any bank without a switch.
  always_comb begin
    gram_nxt   = gram_r;
    com_nxt    = com_r;
    creg_nxt   = creg_r;
    shadow_nxt = shadow_r;
    ptr_nxt    = ptr_r;
    rdata_nxt  = rdata_r;
    done_nxt   = 1'b0;
    if (state_r == CMEM_ST_FETCH) begin
      rdata_nxt = prog_data_in[7:0]; // RULE6
      done_nxt  = 1'b1;
    end else if (do_access && !stall_out) begin
      done_nxt = 1'b1;
      unique case (target)
        CMEM_TGT_CORE: begin
          if (write_in) creg_nxt[index[3:0]] = wdata_in; // RULE13
          rdata_nxt = creg_r[index[3:0]];
        end
        CMEM_TGT_SFR: rdata_nxt = sfr_rdata_in; // RULE8
        CMEM_TGT_GRAM: begin
          if (write_in) gram_nxt[index] = wdata_in; // RULE9
          rdata_nxt = gram_r[index];
        end
        CMEM_TGT_COMMON: begin
          if (write_in) com_nxt[index[3:0]] = wdata_in; // RULE10
          rdata_nxt = com_r[index[3:0]];
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Pointer load and post-increment; the two pointers never alias.
    if (ptr_load_in) begin
      ptr_nxt[ptr_sel_in] = ptr_value_in; // RULE4
    end else if (ptr_inc_in) begin
      ptr_nxt[ptr_sel_in] = ptr_r[ptr_sel_in] + 16'h0001; // RULE5
    end
    // Context save on entry, restore on return.
    if (irq_entry_in) begin
      shadow_nxt = creg_r; // RULE11
    end else if (irq_return_in) begin
      creg_nxt = shadow_r; // RULE11
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r <= CMEM_ST_IDLE;
      rdata_r <= 8'h00;
      done_r  <= 1'b0;
      ptr_r[0] <= PTR_RESET;
      ptr_r[1] <= PTR_RESET;
      for (int i = 0; i < GRAM_SIZE; i++) gram_r[i] <= 8'h00;
      for (int i = 0; i < COMMON_SIZE; i++) com_r[i] <= 8'h00;
      for (int i = 0; i < CORE_REGS; i++) begin
        creg_r[i]   <= 8'h00;
        shadow_r[i] <= 8'h00;
      end
    end else begin
      state_r  <= state_nxt;
      rdata_r  <= rdata_nxt;
      done_r   <= done_nxt;
      ptr_r    <= ptr_nxt;
      gram_r   <= gram_nxt;
      com_r    <= com_nxt;
      creg_r   <= creg_nxt;
      shadow_r <= shadow_nxt;
    end
  end

  assign rdata_out             = rdata_r;
  assign done_out              = done_r;
  assign indirect_pointer0_out = ptr_r[0];
  assign indirect_pointer1_out = ptr_r[1];
  assign core_reg_out          = creg_r;
  // The 49-instruction decoder sits outside; this block serves its pointer ops.
  // RULE12
endmodule : cmem_core
`default_nettype wire

/* File: cmem_decode.sv */
// Address decoder mapping a bank plus offset or a pointer into the unified map.
`timescale 1ns/1ns
`default_nettype none
module cmem_decode
  import cmem_pkg::*;
(
  input  wire logic                 direct_in,
  input  wire logic [4:0]           bank_in,
  input  wire logic [6:0]           offset_in,
  input  wire logic [15:0]          pointer_in,
  output var  cmem_target_type      target_out,
  output logic [6:0]                index_out,
  output logic [14:0]               prog_addr_out
);
  logic [15:0] lin_off;
  logic [6:0]  off;
  logic [4:0]  bank;

  // Pointer values above the data space reach program memory; a linear window
  // reaches the general RAM with no bank bits, so arrays need no bank switching.
  always_comb begin
    target_out    = CMEM_TGT_NONE;
    index_out     = 7'h00;
    prog_addr_out = pointer_in[14:0];
    lin_off       = pointer_in - LINEAR_BASE;
    off           = direct_in ? offset_in : pointer_in[6:0];
    bank          = direct_in ? bank_in : pointer_in[11:7];
    if (!direct_in && pointer_in >= PROG_BASE) begin
      target_out = CMEM_TGT_PROG; // RULE5
    end else if (!direct_in && pointer_in >= LINEAR_BASE) begin
      if (pointer_in <= LINEAR_LIMIT && lin_off[15:0] < 16'(GRAM_BYTES)) begin
        target_out = CMEM_TGT_GRAM; // RULE7
        index_out  = lin_off[6:0];
      end
    end else if (!direct_in && pointer_in[15:12] != 4'h0) begin
      target_out = CMEM_TGT_NONE;
    end else if (off <= CORE_LAST) begin
      target_out = CMEM_TGT_CORE; // RULE13
      index_out  = off;
    end else if (off <= SFR_LAST) begin
      target_out = CMEM_TGT_SFR; // RULE8
      index_out  = off - SFR_FIRST;
    end else if (off < COMMON_FIRST) begin
      if (bank == 5'h00) begin
        target_out = CMEM_TGT_GRAM; // RULE9
        index_out  = off - GRAM_FIRST;
      end
    end else begin
      target_out = CMEM_TGT_COMMON; // RULE10
      index_out  = off - COMMON_FIRST;
    end
  end
endmodule : cmem_decode
`default_nettype wire

/* File: cmem_pkg.sv */
// Package with constants and types for the core stack and banked memory block.
package cmem_pkg;
  localparam int unsigned STACK_WIDTH   = 15;
  localparam int unsigned STACK_DEPTH   = 16;
  localparam int unsigned PTR_WIDTH     = 16;
  localparam int unsigned OFFSET_WIDTH  = 7;
  localparam int unsigned BANK_WIDTH    = 5;
  localparam int unsigned DATA_WIDTH    = 8;
  localparam int unsigned INSN_COUNT    = 49;
  // Bank region boundaries, as 7-bit in-bank offsets.
  localparam logic [6:0] CORE_LAST      = 7'h0b;
  localparam logic [6:0] SFR_FIRST      = 7'h0c;
  localparam logic [6:0] SFR_LAST       = 7'h1f;
  localparam logic [6:0] GRAM_FIRST     = 7'h20;
  localparam logic [6:0] GRAM_LAST      = 7'h6f;
  localparam logic [6:0] COMMON_FIRST   = 7'h70;
  localparam int unsigned GRAM_BYTES    = 80;
  localparam int unsigned COMMON_BYTES  = 16;
  localparam int unsigned CORE_REGS     = 12;
  // Unified pointer space windows.
  localparam logic [15:0] LINEAR_BASE   = 16'h2000;
  localparam logic [15:0] LINEAR_LIMIT  = 16'h29af;
  localparam logic [15:0] PROG_BASE     = 16'h8000;
  // Reset values.
  localparam logic [15:0] PTR_RESET     = 16'h0000;
  localparam logic [4:0]  SP_RESET      = 5'h00;
  // Unified space target of an access.
  typedef enum logic [2:0] {
    CMEM_TGT_CORE   = 3'b000,
    CMEM_TGT_SFR    = 3'b001,
    CMEM_TGT_GRAM   = 3'b010,
    CMEM_TGT_COMMON = 3'b011,
    CMEM_TGT_PROG   = 3'b100,
    CMEM_TGT_NONE   = 3'b101
  } cmem_target_type;
  // Indirect access sequencing.
  typedef enum logic [1:0] {
    CMEM_ST_IDLE  = 2'b00,
    CMEM_ST_FETCH = 2'b01
  } cmem_state_type;
endpackage : cmem_pkg

/* File: cpu_core_stack_and_banked_memory_test.sv */
// Self-checking testbench for the core stack and banked memory block.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_stack_and_banked_memory_test;
  import cmem_pkg::*;
  logic        clk_in, srst_in, push_in, pop_in, stack_fault_reset_en_in, flags_clear_in;
  logic        ptr_load_in, ptr_sel_in, ptr_inc_in, access_in, indirect_in, write_in;
  logic        stack_overflow_flag_out, stack_underflow_flag_out, soft_reset_out, stall_out;
  logic        done_out, sfr_sel_out, prog_req_out, irq_entry_in, irq_return_in;
  logic [14:0] push_addr_in, top_addr_out, prog_addr_out;
  logic [4:0]  stack_level_out, bank_in, sfr_index_out;
  logic [15:0] ptr_value_in, indirect_pointer0_out, indirect_pointer1_out;
  logic [6:0]  offset_in;
  logic [7:0]  wdata_in, rdata_out, sfr_rdata_in, rd;
  logic [13:0] prog_data_in;
  logic [7:0]  core_reg_out [CORE_REGS];
  int          err_count, tests_run, cycles, rst_seen, n, req_seen;
  cmem_core u_dut (.clk_in, .srst_in, .push_in, .pop_in, .push_addr_in, .top_addr_out,
    .stack_level_out, .stack_fault_reset_en_in, .stack_overflow_flag_out,
    .stack_underflow_flag_out, .flags_clear_in, .soft_reset_out, .ptr_load_in, .ptr_sel_in,
    .ptr_value_in, .ptr_inc_in, .indirect_pointer0_out, .indirect_pointer1_out, .access_in,
    .indirect_in, .write_in, .bank_in, .offset_in, .wdata_in, .rdata_out, .stall_out,
    .done_out, .sfr_sel_out, .sfr_index_out, .sfr_rdata_in, .prog_req_out, .prog_addr_out,
    .prog_data_in, .irq_entry_in, .irq_return_in, .core_reg_out);
  // Clock at 20 MHz.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Cycle ceiling well above the roughly 150 cycles the run needs; also counts reset
  // pulses and program fetch requests.
  always @(posedge clk_in) begin
    cycles++;
    if (soft_reset_out === 1'b1) rst_seen++;
    if (prog_req_out === 1'b1) req_seen++;
    if (cycles > 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One push (ps=1) or pop (ps=0), then one idle edge so reset pulses are counted.
  task automatic stk(input logic ps, input logic [14:0] a);
    @(negedge clk_in);
    push_in = ps;
    pop_in = !ps;
    push_addr_in = a;
    @(negedge clk_in);
    push_in = 1'b0;
    pop_in = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic ldp(input logic s, input logic [15:0] v);
    @(negedge clk_in);
    ptr_load_in = 1'b1;
    ptr_sel_in = s;
    ptr_value_in = v;
    @(negedge clk_in);
    ptr_load_in = 1'b0;
  endtask
  // One access; n counts the extra cycles before done_out, bounded at four.
  task automatic acc(input logic ind, wr, input logic [4:0] b, input logic [6:0] o,
                     input logic [7:0] d);
    @(negedge clk_in);
    {access_in, indirect_in, write_in, bank_in, offset_in, wdata_in} = {1'b1, ind, wr, b, o, d};
    @(negedge clk_in);
    access_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    rd = rdata_out;
  endtask
  task automatic t_stack();
    for (int i = 0; i < 16; i++) stk(1'b1, 15'h0100 + 15'(i));
    chk("full level", 16'h0010, 16'(stack_level_out));
    stk(1'b1, 15'h7fff);
    chk("overflow flag", 16'h0001, 16'(stack_overflow_flag_out));
    chk("top after overflow", 16'h010f, 16'(top_addr_out));
    chk("reset disabled", 16'h0000, 16'(rst_seen));
    for (int i = 15; i >= 0; i--) begin
      chk("stack top", 16'h0100 + 16'(i), 16'(top_addr_out));
      stk(1'b0, 15'h0000);
    end
    stack_fault_reset_en_in = 1'b1;
    stk(1'b0, 15'h0000);
    chk("underflow flag", 16'h0001, 16'(stack_underflow_flag_out));
    chk("fault reset", 16'h0001, 16'(rst_seen));
    flags_clear_in = 1'b1;
    @(negedge clk_in);
    flags_clear_in = 1'b0;
    chk("flags cleared", 16'h0000, 16'({stack_overflow_flag_out, stack_underflow_flag_out}));
  endtask
  task automatic t_map();
    ldp(1'b0, 16'h2000);
    ldp(1'b1, 16'h8123);
    chk("pointer zero", 16'h2000, indirect_pointer0_out);
    chk("pointer one", 16'h8123, indirect_pointer1_out);
    @(negedge clk_in);
    {ptr_sel_in, ptr_inc_in} = 2'b01;
    @(negedge clk_in);
    ptr_inc_in = 1'b0;
    chk("pointer step", 16'h2001, indirect_pointer0_out);
    acc(1'b1, 1'b1, 5'h00, 7'h00, 8'h96);
    acc(1'b0, 1'b0, 5'h00, 7'h21, 8'h00);
    chk("linear ram", 16'h0096, 16'(rd));
    acc(1'b0, 1'b0, 5'h01, 7'h21, 8'h00);
    chk("unmapped ram", 16'h0000, 16'(rd));
    acc(1'b0, 1'b1, 5'h00, 7'h70, 8'h3c);
    acc(1'b0, 1'b0, 5'h1f, 7'h7f, 8'h00);
    acc(1'b0, 1'b0, 5'h05, 7'h70, 8'h00);
    chk("common ram", 16'h003c, 16'(rd));
    chk("plain latency", 16'h0000, 16'(n));
    acc(1'b0, 1'b0, 5'h02, 7'h0c, 8'h00);
    chk("special register", 16'h005a, 16'(rd));
    ptr_sel_in = 1'b1;
    acc(1'b1, 1'b0, 5'h00, 7'h00, 8'h00);
    chk("program byte", 16'h00a5, 16'(rd));
    chk("program latency", 16'h0001, 16'(n));
    chk("program request", 16'h0001, 16'(req_seen));
    chk("program address", 16'h0123, 16'(prog_addr_out));
    acc(1'b0, 1'b1, 5'h00, 7'h05, 8'h11);
    acc(1'b0, 1'b0, 5'h03, 7'h05, 8'h00);
    chk("core register", 16'h0011, 16'(rd));
    ldp(1'b1, 16'h0285);
    acc(1'b1, 1'b0, 5'h00, 7'h00, 8'h00);
    chk("banked pointer", 16'h0011, 16'(rd));
  endtask
  task automatic t_shadow();
    @(negedge clk_in);
    irq_entry_in = 1'b1;
    @(negedge clk_in);
    irq_entry_in = 1'b0;
    acc(1'b0, 1'b1, 5'h00, 7'h05, 8'h22);
    chk("core changed", 16'h0022, 16'(core_reg_out[5]));
    irq_return_in = 1'b1;
    @(negedge clk_in);
    irq_return_in = 1'b0;
    @(negedge clk_in);
    chk("core restored", 16'h0011, 16'(core_reg_out[5]));
  endtask
  // All inputs defined at time zero; reset held four cycles.
  initial begin
    {srst_in, push_in, pop_in, stack_fault_reset_en_in, flags_clear_in} = 5'h10;
    {ptr_load_in, ptr_sel_in, ptr_inc_in, access_in, indirect_in, write_in} = 6'h00;
    {irq_entry_in, irq_return_in, push_addr_in, bank_in, offset_in} = 29'h0;
    {ptr_value_in, wdata_in} = 24'h0;
    sfr_rdata_in = 8'h5a;
    prog_data_in = 14'h02a5;
    repeat (4) @(negedge clk_in);
    srst_in = 1'b0;
    t_stack();
    t_map();
    t_shadow();
    report_and_stop();
  end
endmodule // cpu_core_stack_and_banked_memory_test
bind cmem_core cmem_chk u_chk (.clk_in, .srst_in, .push_in, .pop_in, .push_addr_in,
  .stack_fault_reset_en_in, .stack_level_out, .top_addr_out, .stack_overflow_flag_out,
  .stack_underflow_flag_out, .soft_reset_out, .ptr_load_in, .ptr_sel_in, .ptr_value_in,
  .indirect_pointer0_out, .indirect_pointer1_out, .access_in, .indirect_in, .offset_in,
  .sfr_sel_out, .sfr_index_out, .stall_out, .done_out);
`default_nettype wire
